// ===== common/fcz_consts.svh
// Function
// - Outcome lands on three adjacent result bits: greater, equal, less.
// - While enabled exactly one result bit is set, the others cleared.
// - With enable low nothing executes and result bits hold their values, except that result_clear sets them to zero.
// - Integer constant operands are converted to single-precision float before comparing.
// - Two-operand: bit0 when a greater, bit1 when equal, bit2 when smaller.
// - Zone: bit0 below lower, bit1 inside inclusive, bit2 above upper.
// - Lower above upper degrades to plain compare with lower as operand one.
`ifndef FCZ_CONSTS_SVH
`define FCZ_CONSTS_SVH
`define FCZ_BIT_GT 0
`define FCZ_BIT_EQ 1
`define FCZ_BIT_LT 2
`define FCZ_RES_RST 3'h0
`endif

// ===== common/fcz_pkg.sv
package fcz_pkg;
  typedef enum logic [0:0] {
    MODE_TWO  = 1'b0,
    MODE_ZONE = 1'b1
  } mode_t;
endpackage

// ===== logic/float_compare_zone_unit.sv
`timescale 1ns/10ps
`include "fcz_consts.svh"
module float_compare_zone_unit (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           enable_input,
  input  wire fcz_pkg::mode_t mode,
  input  wire logic [15:0]    a_lo,
  input  wire logic [15:0]    a_hi,
  input  wire logic           a_is_int,
  input  wire logic [15:0]    b_lo,
  input  wire logic [15:0]    b_hi,
  input  wire logic           b_is_int,
  input  wire logic [15:0]    v_lo,
  input  wire logic [15:0]    v_hi,
  input  wire logic           v_is_int,
  input  wire logic           result_clear,
  output logic [2:0]          result_bits
);

  // Registered result field; it only changes on a compare, a clear or reset.
  logic [2:0]  result_ff;
  logic [2:0]  nxt_result;

  // Operands after word pairing and optional integer conversion.
  logic [31:0] fa;
  logic [31:0] fb;
  logic [31:0] fv;

  // Order keys: an unsigned compare of two keys gives the numeric float order.
  logic [31:0] key_a;
  logic [31:0] key_b;
  logic [31:0] key_v;

  // Candidate outcomes, one per instruction form plus the reversed-bounds fallback.
  logic [2:0]  two_res;
  logic [2:0]  zone_res;
  logic [2:0]  swap_res;
  logic        bounds_swapped;
  logic [2:0]  cmp_res;

  // Position of the highest set bit, or zero for an all-zero word.
  function automatic int lead_one(
    input logic [31:0] m
  );
    int pos;

    pos = 0;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        pos = i;
      end
    end
    lead_one = pos;
  endfunction

  // Converts a signed 32-bit integer to single precision.
  // Bits below the 24-bit mantissa are truncated, not rounded, so large
  // integers compare as the nearest float towards zero.
  function automatic logic [31:0] int_to_float(
    input logic [31:0] w
  );
    logic        s;
    logic [31:0] mag;
    logic [31:0] norm;
    logic [7:0]  e;
    int          p;

    s = w[31];
    mag = s ? (~w + 32'h1) : w;
    p = lead_one(mag);
    e = 8'h0;
    norm = 32'h0;

    if (mag == 32'h0) begin
      int_to_float = 32'h0;
    end else begin
      norm = mag << (31 - p);
      e = 8'(127 + p);
      int_to_float = {s, e, norm[30:8]};
    end
  endfunction

  // Maps a float to an unsigned key whose order matches numeric order.
  // Both zeros map to one key so that plus and minus zero compare equal.
  // Not-a-number patterns get no special treatment; they order by bit pattern.
  function automatic logic [31:0] float_key(
    input logic [31:0] f
  );
    logic [31:0] g;

    g = (f[30:0] == 31'h0) ? 32'h0 : f;
    float_key = g[31] ? ~g : {1'b1, g[30:0]};
  endfunction

  // Joins two storage words into one operand, converting an integer constant.
  function automatic logic [31:0] word_pair(
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic        is_int
  );
    logic [31:0] w;

    w = {hi, lo};
    if (is_int) begin
      word_pair = int_to_float(w);
    end else begin
      word_pair = w;
    end
  endfunction

  // Returns greater, equal or less of kx against ky in result field order.
  function automatic logic [2:0] order3(
    input logic [31:0] kx,
    input logic [31:0] ky
  );
    order3 = 3'h0;
    if (kx > ky) begin
      order3[`FCZ_BIT_GT] = 1'b1;
    end else if (kx == ky) begin
      order3[`FCZ_BIT_EQ] = 1'b1;
    end else begin
      order3[`FCZ_BIT_LT] = 1'b1;
    end
  endfunction

  // Operand decode is shared by both instruction forms.
  always_comb begin
    fa = word_pair(a_lo, a_hi, a_is_int);
    fb = word_pair(b_lo, b_hi, b_is_int);
    fv = word_pair(v_lo, v_hi, v_is_int);
  end

  always_comb begin
    key_a = float_key(fa);
    key_b = float_key(fb);
    key_v = float_key(fv);
  end

  // Two-operand form: operand one against operand two.
  always_comb begin
    two_res = order3(key_a, key_b);
  end

  // Zone form with ordered bounds; both bounds count as inside.
  // The low bit means below the zone, the high bit above it.
  always_comb begin
    zone_res = 3'h0;
    if (key_v < key_a) begin
      zone_res[`FCZ_BIT_GT] = 1'b1;
    end else if (key_v > key_b) begin
      zone_res[`FCZ_BIT_LT] = 1'b1;
    end else begin
      zone_res[`FCZ_BIT_EQ] = 1'b1;
    end
  end

  // Reversed bounds fall back to a plain compare of the lower bound
  // against the value, so a badly ordered zone still yields one bit.
  always_comb begin
    bounds_swapped = (key_a > key_b);
    swap_res = order3(key_a, key_v);
  end

  // Picks the outcome of the instruction form in use.
  always_comb begin
    case (mode)
      fcz_pkg::MODE_TWO: begin
        cmp_res = two_res;
      end
      fcz_pkg::MODE_ZONE: begin
        if (bounds_swapped) begin
          cmp_res = swap_res;
        end else begin
          cmp_res = zone_res;
        end
      end
      default: begin
        cmp_res = two_res;
      end
    endcase
  end

  // A compare in the same cycle as a clear wins, so the field never
  // reads all zero right after an executed compare.
  always_comb begin
    nxt_result = result_ff;
    if (result_clear) begin
      nxt_result = `FCZ_RES_RST;
    end
    if (enable_input) begin
      nxt_result = cmp_res;
    end
  end

  // The result is held with enable low, so a stale outcome stays visible until cleared.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_ff <= `FCZ_RES_RST;
    end else begin
      result_ff <= nxt_result;
    end
  end

  assign result_bits = result_ff;

endmodule

// ===== verif/word_store.sv
`timescale 1ns/10ps
module word_store (
  input  logic [31:0] val,
  output logic [15:0] lo,
  output logic [15:0] hi
);
  // The low word sits at the lower address of the pair.
  assign {hi, lo} = val;
endmodule

// ===== verif/fcz_props.sv
`timescale 1ns/10ps
module fcz_props (
  input logic           clk,
  input logic           nrst,
  input logic           enable_input,
  input fcz_pkg::mode_t mode,
  input logic [15:0]    a_lo,
  input logic [15:0]    a_hi,
  input logic           a_is_int,
  input logic [15:0]    b_lo,
  input logic [15:0]    b_hi,
  input logic           b_is_int,
  input logic [15:0]    v_lo,
  input logic [15:0]    v_hi,
  input logic           v_is_int,
  input logic           result_clear,
  input logic [2:0]     result_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_idle_hold: assert property (!enable_input && !result_clear |=> $stable(result_bits))
    else $error("Result bits moved while idle.");
  a_one_hot: assert property (enable_input |=> $onehot(result_bits))
    else $error("Result bits not one-hot after a compare.");
  a_clear_zero: assert property (result_clear && !enable_input |=> result_bits == 3'h0)
    else $error("Clear did not zero the result bits.");
  a_compare_wins: assert property (enable_input && result_clear |=> result_bits != 3'h0)
    else $error("Clear overrode a compare.");
  a_two_equal: assert property (
    enable_input && mode == fcz_pkg::MODE_TWO && a_is_int == b_is_int && {a_hi, a_lo} == {b_hi, b_lo}
    |=> result_bits == 3'h2)
    else $error("Equal operands not reported equal.");
  a_zone_equal: assert property (
    enable_input && mode == fcz_pkg::MODE_ZONE && a_is_int == b_is_int && a_is_int == v_is_int
    && {a_hi, a_lo} == {b_hi, b_lo} && {a_hi, a_lo} == {v_hi, v_lo}
    |=> result_bits == 3'h2)
    else $error("Value on a point zone not reported inside.");
  c_run: cover property (enable_input);
  c_clr: cover property (result_clear);
  c_idle: cover property (!enable_input);
  c_zone: cover property (enable_input && mode == fcz_pkg::MODE_ZONE);
endmodule
bind float_compare_zone_unit fcz_props p (
  .clk          (clk),
  .nrst         (nrst),
  .enable_input (enable_input),
  .mode         (mode),
  .a_lo         (a_lo),
  .a_hi         (a_hi),
  .a_is_int     (a_is_int),
  .b_lo         (b_lo),
  .b_hi         (b_hi),
  .b_is_int     (b_is_int),
  .v_lo         (v_lo),
  .v_hi         (v_hi),
  .v_is_int     (v_is_int),
  .result_clear (result_clear),
  .result_bits  (result_bits)
);

// ===== verif/test_float_compare_zone_unit.sv
`timescale 1ns/10ps
module test_float_compare_zone_unit;
  logic           clk;
  logic           nrst;
  logic           enable_input;
  logic           result_clear;
  fcz_pkg::mode_t mode;
  logic           a_is_int;
  logic           b_is_int;
  logic           v_is_int;
  logic [31:0]    a_word;
  logic [15:0]    a_lo;
  logic [15:0]    a_hi;
  logic [15:0]    b_lo;
  logic [15:0]    b_hi;
  logic [15:0]    v_lo;
  logic [15:0]    v_hi;
  logic [2:0]     result_bits;
  int             error_cnt;
  int             cmp_count;
  always #5 clk = ~clk;
  word_store ws (.val(a_word), .lo(a_lo), .hi(a_hi));
  float_compare_zone_unit DUT (
    .clk          (clk),
    .nrst         (nrst),
    .enable_input (enable_input),
    .mode         (mode),
    .a_lo         (a_lo),
    .a_hi         (a_hi),
    .a_is_int     (a_is_int),
    .b_lo         (b_lo),
    .b_hi         (b_hi),
    .b_is_int     (b_is_int),
    .v_lo         (v_lo),
    .v_hi         (v_hi),
    .v_is_int     (v_is_int),
    .result_clear (result_clear),
    .result_bits  (result_bits)
  );
  task automatic check_bits(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Flags k are enable, clear, zone, and integer marks of a, b and v.
  task automatic go(input logic [5:0] k, input logic [31:0] x, input logic [31:0] y, input logic [31:0] w,
                    input logic [2:0] e);
    @(negedge clk);
    enable_input = k[5];
    result_clear = k[4];
    mode         = fcz_pkg::mode_t'(k[3]);
    a_is_int     = k[2];
    b_is_int     = k[1];
    v_is_int     = k[0];
    a_word       = x;
    {b_hi, b_lo} = y;
    {v_hi, v_lo} = w;
    @(negedge clk);
    enable_input = 1'b0;
    result_clear = 1'b0;
    check_bits(result_bits, e);
  endtask
  task automatic two_op();
    go(6'b100010, 32'h40000000, 32'h1, 32'h0, 3'h1);
    go(6'b100110, 32'hffffffff, 32'h1, 32'h0, 3'h4);
    go(6'b100000, 32'h3f800000, 32'h3f800000, 32'h0, 3'h2);
  endtask
  task automatic zone_hold();
    go(6'b101110, 32'h1, 32'h3, 32'h40400000, 3'h2);
    go(6'b101111, 32'h1, 32'h3, 32'h0, 3'h1);
    go(6'b101111, 32'h1, 32'h3, 32'h4, 3'h4);
    go(6'b101110, 32'h3, 32'h1, 32'h40000000, 3'h1);
    go(6'b001110, 32'h5, 32'h6, 32'h0, 3'h1);
    go(6'b111111, 32'h2, 32'h2, 32'h2, 3'h2);
    go(6'b011000, 32'h0, 32'h0, 32'h0, 3'h0);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // About 22 cycles are needed; the ceiling leaves wide margin.
  initial begin
    repeat (200) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    clk          = 1'b0;
    nrst         = 1'b0;
    enable_input = 1'b0;
    result_clear = 1'b0;
    mode         = fcz_pkg::MODE_TWO;
    a_is_int     = 1'b0;
    b_is_int     = 1'b0;
    v_is_int     = 1'b0;
    a_word       = 32'h0;
    {b_hi, b_lo} = 32'h0;
    {v_hi, v_lo} = 32'h0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    two_op();
    zone_hold();
    tally_and_finish();
  end
endmodule
